// ===== shared/hdlcr_pkg.sv
package hdlcr_pkg;

   // Register port widths.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register offsets, as byte addresses on the register port.
   localparam logic [7:0] OFF_DRIVE_FLOOR = 8'h14;
   localparam logic [7:0] OFF_DRIVE_CEILING = 8'h15;
   localparam logic [7:0] OFF_NOMINAL_LEVEL = 8'h16;
   localparam logic [7:0] OFF_OVERDRIVE_LIMIT = 8'h17;
   localparam logic [7:0] OFF_LOSS_COMP = 8'h18;
   localparam logic [7:0] OFF_BACKEMF_CAL = 8'h19;
   localparam logic [7:0] OFF_CAL_STATUS = 8'h30;

   // Reset values.
   localparam logic [7:0] RST_DRIVE_FLOOR = 8'h19;
   localparam logic [7:0] RST_DRIVE_CEILING = 8'hff;
   localparam logic [7:0] RST_NOMINAL_LEVEL = 8'h3e;
   localparam logic [7:0] RST_OVERDRIVE_LIMIT = 8'h8c;
   localparam logic [7:0] RST_LOSS_COMP = 8'h0c;
   localparam logic [7:0] RST_BACKEMF_CAL = 8'h6f;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // Status register bit positions.
   localparam int STAT_NOMINAL_STALE_BIT = 0;
   localparam int STAT_CAL_SEEN_BIT = 1;

   // Full scale of every 8-bit level, the divisor of all ratio fields.
   localparam logic [15:0] FULL_SCALE_DIV = 16'h00ff;
   localparam logic [19:0] FULL_SCALE_DIV_W = 20'h000ff;

   // Back-EMF full-scale voltage in millivolts.
   localparam logic [19:0] BEMF_FS_MV = 20'd1220;

   // Feedback sense gain in tenths, one per select code.
   localparam logic [19:0] SENSE_GAIN_X10_0 = 20'd10;
   localparam logic [19:0] SENSE_GAIN_X10_1 = 20'd20;
   localparam logic [19:0] SENSE_GAIN_X10_2 = 20'd40;
   localparam logic [19:0] SENSE_GAIN_X10_3 = 20'd80;
   localparam logic [19:0] GAIN_TENTHS = 20'd10;

   // Numerator of the loop gain law: gain = numerator / back-EMF result.
   localparam logic [15:0] FB_GAIN_NUM = 16'h1fe0;
   localparam logic [7:0] FB_GAIN_MAX = 8'hff;

   // Which register sets the drive engine's full-scale reference.
   typedef enum logic [1:0] {
      REF_NOMINAL = 2'b00,
      REF_LIMIT_OPEN = 2'b01,
      REF_LIMIT_BOOST = 2'b10
   } hdlcr_ref_sel_type;

endpackage

// ===== logic/hdlcr_reg8.sv
`timescale 1ns/1ps
`default_nettype none

// One 8-bit register that software writes and that hardware may load.
module hdlcr_reg8 #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic hw_load,
   input wire logic [7:0] hw_data,
   output logic [7:0] value
);

   logic [7:0] value_q;
   logic [7:0] value_d;

   // A hardware load beats a software write in the same cycle, so a fresh result is never lost.
   assign value_d = hw_load ? hw_data : (wr_en ? wr_data : value_q);
   assign value = value_q;

   // Storage flop.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         value_q <= RESET_VALUE;
      end else begin
         value_q <= value_d;
      end
   end

endmodule

`default_nettype wire

// ===== logic/hdlcr_ratio_scale.sv
`timescale 1ns/1ps
`default_nettype none

// Scales a level by a ratio field: result = level * ratio / 255.
module hdlcr_ratio_scale (
   input wire logic [7:0] level,
   input wire logic [7:0] ratio,
   output logic [7:0] scaled
);
   import hdlcr_pkg::*;

   logic [15:0] product;
   logic [15:0] quotient;

   // The quotient never exceeds 255, so the cut to eight bits loses nothing.
   assign product = level * ratio;
   assign quotient = product / FULL_SCALE_DIV;
   assign scaled = quotient[7:0];

endmodule

`default_nettype wire

// ===== logic/hdlcr_top.sv
// Overview of operation
// [RULE_01] Drive floor register, reset 0x19, sets lowest audio-path output level.
// [RULE_02] Drive ceiling register, reset 0xff, caps audio-path output at ceiling/255.
// [RULE_03] Closed loop uses nominal level register, reset 0x3e, as full-scale reference.
// [RULE_04] Host loads nominal level before calibration; calibration reads it as input.
// [RULE_05] Open loop ignores nominal level and uses overdrive limit instead.
// [RULE_06] Host should recalibrate after any change of the nominal level.
// [RULE_07] Closed-loop overdrive and braking may drive above the nominal level.
// [RULE_08] Overdrive limit register, reset 0x8c, bounds automatic overdrive.
// [RULE_09] Open loop takes its full-scale reference from the overdrive limit.
// [RULE_10] Calibration completion stores loss compensation result; reset value 0x0c.
// [RULE_11] Playback drive gain is multiplied by one plus compensation/255.
// [RULE_12] Calibration completion stores back-EMF result; reset value 0x6f.
// [RULE_13] Closed-loop feedback gain is derived from the back-EMF result.
// [RULE_14] Back-EMF volts equal result/255 times 1.22 V over sense gain.
// [RULE_15] Both calibration results stay host writable to restore saved values.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module hdlcr_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [hdlcr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [hdlcr_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [hdlcr_pkg::DATA_W-1:0] reg_rdata,
   input wire logic closed_loop,
   input wire logic overdrive_active,
   input wire logic brake_active,
   input wire logic [1:0] feedback_sense_gain_select,
   input wire logic cal_done,
   input wire logic [7:0] cal_comp_value,
   input wire logic [7:0] cal_bemf_value,
   input wire logic [7:0] ath_level_in,
   input wire logic [7:0] drive_request,
   output logic [7:0] calib_reference,
   output logic [7:0] full_scale_ref,
   output hdlcr_pkg::hdlcr_ref_sel_type ref_select,
   output logic [7:0] ath_drive_level,
   output logic [8:0] drive_amplitude,
   output logic [7:0] feedback_gain,
   output logic [15:0] backemf_sense_mv
);
   import hdlcr_pkg::*;

   // Address decode of the register port.
   logic hit_floor;
   logic hit_ceiling;
   logic hit_nominal;
   logic hit_limit;
   logic hit_comp;
   logic hit_bemf;
   logic hit_status;
   assign hit_floor = (reg_addr == OFF_DRIVE_FLOOR);
   assign hit_ceiling = (reg_addr == OFF_DRIVE_CEILING);
   assign hit_nominal = (reg_addr == OFF_NOMINAL_LEVEL);
   assign hit_limit = (reg_addr == OFF_OVERDRIVE_LIMIT);
   assign hit_comp = (reg_addr == OFF_LOSS_COMP);
   assign hit_bemf = (reg_addr == OFF_BACKEMF_CAL);
   assign hit_status = (reg_addr == OFF_CAL_STATUS);

   // Write enables per register.
   logic wr_floor;
   logic wr_ceiling;
   logic wr_nominal;
   logic wr_limit;
   logic wr_comp;
   logic wr_bemf;
   assign wr_floor = reg_wr & hit_floor;
   assign wr_ceiling = reg_wr & hit_ceiling;
   assign wr_nominal = reg_wr & hit_nominal;
   assign wr_limit = reg_wr & hit_limit;
   assign wr_comp = reg_wr & hit_comp;
   assign wr_bemf = reg_wr & hit_bemf;

   logic [7:0] drive_floor;
   logic [7:0] drive_ceiling;
   logic [7:0] nominal_level;
   logic [7:0] overdrive_limit;
   logic [7:0] loss_comp;
   logic [7:0] backemf_result;

   // Audio path floor, host only.
   hdlcr_reg8 #(.RESET_VALUE(RST_DRIVE_FLOOR)) u_floor ( // RULE_01
      .clk(clk),
      .rst(rst),
      .wr_en(wr_floor),
      .wr_data(reg_wdata),
      .hw_load(1'b0),
      .hw_data(RST_ZERO),
      .value(drive_floor)
   );

   // Audio path ceiling, host only.
   hdlcr_reg8 #(.RESET_VALUE(RST_DRIVE_CEILING)) u_ceiling ( // RULE_02
      .clk(clk),
      .rst(rst),
      .wr_en(wr_ceiling),
      .wr_data(reg_wdata),
      .hw_load(1'b0),
      .hw_data(RST_ZERO),
      .value(drive_ceiling)
   );

   // Motor nominal level, host only.
   hdlcr_reg8 #(.RESET_VALUE(RST_NOMINAL_LEVEL)) u_nominal ( // RULE_03
      .clk(clk),
      .rst(rst),
      .wr_en(wr_nominal),
      .wr_data(reg_wdata),
      .hw_load(1'b0),
      .hw_data(RST_ZERO),
      .value(nominal_level)
   );

   // Overdrive limit, host only.
   hdlcr_reg8 #(.RESET_VALUE(RST_OVERDRIVE_LIMIT)) u_limit ( // RULE_08
      .clk(clk),
      .rst(rst),
      .wr_en(wr_limit),
      .wr_data(reg_wdata),
      .hw_load(1'b0),
      .hw_data(RST_ZERO),
      .value(overdrive_limit)
   );

   // Loss compensation result: loaded by calibration, still writable by the host.
   hdlcr_reg8 #(.RESET_VALUE(RST_LOSS_COMP)) u_comp ( // RULE_10 RULE_15
      .clk(clk),
      .rst(rst),
      .wr_en(wr_comp),
      .wr_data(reg_wdata),
      .hw_load(cal_done),
      .hw_data(cal_comp_value),
      .value(loss_comp)
   );

   // Back-EMF result: loaded by calibration, still writable by the host.
   hdlcr_reg8 #(.RESET_VALUE(RST_BACKEMF_CAL)) u_bemf ( // RULE_12 RULE_15
      .clk(clk),
      .rst(rst),
      .wr_en(wr_bemf),
      .wr_data(reg_wdata),
      .hw_load(cal_done),
      .hw_data(cal_bemf_value),
      .value(backemf_result)
   );

   // Calibration status flags.
   logic nominal_stale_q;
   logic nominal_stale_d;
   logic cal_seen_q;
   logic cal_seen_d;

   // A nominal-level write in the same cycle as a calibration end leaves the result stale,
   // because the routine finished with the old level.
   assign nominal_stale_d = wr_nominal ? 1'b1 : (cal_done ? 1'b0 : nominal_stale_q); // RULE_06
   assign cal_seen_d = cal_seen_q | cal_done;

   // Status flops.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nominal_stale_q <= 1'b0;
         cal_seen_q <= 1'b0;
      end else begin
         nominal_stale_q <= nominal_stale_d;
         cal_seen_q <= cal_seen_d;
      end
   end

   logic [7:0] status_word;
   assign status_word = {6'h00, cal_seen_q, nominal_stale_q};

   // Read data multiplexer; unmapped addresses read as zero.
   logic [7:0] rd_mux;
   assign rd_mux = hit_floor ? drive_floor :
                   hit_ceiling ? drive_ceiling :
                   hit_nominal ? nominal_level :
                   hit_limit ? overdrive_limit :
                   hit_comp ? loss_comp :
                   hit_bemf ? backemf_result :
                   hit_status ? status_word : RST_ZERO;

   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   // Data stand only in the cycle after the read strobe, zero otherwise.
   assign rdata_d = reg_rd ? rd_mux : RST_ZERO;

   // Read data flop.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= RST_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata = rdata_q;

   // Reference selection: the limit replaces the nominal level in open loop and,
   // in closed loop, while overdrive or braking runs.
   logic boost_window;
   hdlcr_ref_sel_type ref_sel;
   assign boost_window = closed_loop & (overdrive_active | brake_active); // RULE_07
   assign ref_sel = !closed_loop ? REF_LIMIT_OPEN : // RULE_05 RULE_09
                    (boost_window ? REF_LIMIT_BOOST : REF_NOMINAL); // RULE_03

   logic [7:0] ref_level;
   // Map the selection onto a register value.
   always_comb begin
      unique case (ref_sel)
         REF_NOMINAL: ref_level = nominal_level;
         REF_LIMIT_OPEN: ref_level = overdrive_limit;
         REF_LIMIT_BOOST: ref_level = overdrive_limit;
         default: ref_level = nominal_level;
      endcase
   end

   // Drive amplitude: request scaled by the reference, then by the loss coefficient.
   logic [7:0] drive_scaled;
   logic [7:0] comp_extra;
   logic [8:0] drive_comp;
   logic [8:0] limit_wide;
   logic [8:0] drive_bounded;

   hdlcr_ratio_scale u_drive_scale (
      .level(drive_request),
      .ratio(ref_level),
      .scaled(drive_scaled)
   );

   hdlcr_ratio_scale u_comp_scale (
      .level(drive_scaled),
      .ratio(loss_comp),
      .scaled(comp_extra)
   );

   // Coefficient 1 + comp/255 applied as level plus level*comp/255.
   assign drive_comp = {1'b0, drive_scaled} + {1'b0, comp_extra}; // RULE_11
   assign limit_wide = {1'b0, overdrive_limit};
   // Compensation may lift a boosted drive past the limit, so the bound is applied last.
   assign drive_bounded = (boost_window && (drive_comp > limit_wide)) ? limit_wide : drive_comp; // RULE_08

   // Audio path output level: silence stays silent, any signal is raised to the floor
   // and cut at the ceiling. A floor above the ceiling yields the ceiling.
   logic [7:0] ath_floored;
   logic [7:0] ath_limited;
   assign ath_floored = (ath_level_in < drive_floor) ? drive_floor : ath_level_in; // RULE_01
   assign ath_limited = (ath_floored > drive_ceiling) ? drive_ceiling : ath_floored; // RULE_02

   logic [7:0] ath_level_d;
   assign ath_level_d = (ath_level_in == RST_ZERO) ? RST_ZERO : ath_limited;

   // Loop gain law: a weaker back-EMF needs a larger gain. A zero result saturates.
   logic [15:0] gain_quot;
   logic [7:0] fb_gain_d;
   assign gain_quot = (backemf_result == RST_ZERO) ? 16'h0000 :
                      FB_GAIN_NUM / {8'h00, backemf_result};
   assign fb_gain_d = ((backemf_result == RST_ZERO) || (gain_quot > 16'h00ff)) ? FB_GAIN_MAX :
                      gain_quot[7:0]; // RULE_13

   // Back-EMF in millivolts, divided by the selected sense gain.
   logic [19:0] bemf_prod;
   logic [19:0] bemf_mv_raw;
   logic [19:0] sense_gain;
   logic [19:0] bemf_sense;
   assign bemf_prod = 20'(backemf_result) * BEMF_FS_MV;
   assign bemf_mv_raw = bemf_prod / FULL_SCALE_DIV_W; // RULE_14
   assign sense_gain = (feedback_sense_gain_select == 2'h0) ? SENSE_GAIN_X10_0 :
                       (feedback_sense_gain_select == 2'h1) ? SENSE_GAIN_X10_1 :
                       (feedback_sense_gain_select == 2'h2) ? SENSE_GAIN_X10_2 :
                       SENSE_GAIN_X10_3;
   assign bemf_sense = 20'(bemf_mv_raw * GAIN_TENTHS) / sense_gain; // RULE_14

   // Output flops toward the drive engine and calibration routine.
   logic [7:0] calib_ref_q;
   logic [7:0] full_scale_q;
   hdlcr_ref_sel_type ref_sel_q;
   logic [7:0] ath_level_q;
   logic [8:0] drive_amp_q;
   logic [7:0] fb_gain_q;
   logic [15:0] bemf_mv_q;

   // One register stage keeps every engine-facing output glitch free.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         calib_ref_q <= RST_NOMINAL_LEVEL;
         full_scale_q <= RST_NOMINAL_LEVEL;
         ref_sel_q <= REF_NOMINAL;
         ath_level_q <= RST_ZERO;
         drive_amp_q <= 9'h000;
         fb_gain_q <= RST_ZERO;
         bemf_mv_q <= 16'h0000;
      end else begin
         calib_ref_q <= nominal_level; // RULE_04
         full_scale_q <= ref_level;
         ref_sel_q <= ref_sel;
         ath_level_q <= ath_level_d;
         drive_amp_q <= drive_bounded;
         fb_gain_q <= fb_gain_d;
         bemf_mv_q <= bemf_sense[15:0];
      end
   end

   assign calib_reference = calib_ref_q;
   assign full_scale_ref = full_scale_q;
   assign ref_select = ref_sel_q;
   assign ath_drive_level = ath_level_q;
   assign drive_amplitude = drive_amp_q;
   assign feedback_gain = fb_gain_q;
   assign backemf_sense_mv = bemf_mv_q;

endmodule

`default_nettype wire

// ===== sim/hdlcr_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the level bank from its ports only; one clock domain throughout.
module hdlcr_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic [hdlcr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [hdlcr_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [hdlcr_pkg::DATA_W-1:0] reg_rdata,
   input wire logic closed_loop,
   input wire logic overdrive_active,
   input wire logic brake_active,
   input wire logic cal_done,
   input wire logic [7:0] cal_comp_value,
   input wire logic [7:0] cal_bemf_value,
   input wire logic [7:0] calib_reference,
   input wire logic [7:0] full_scale_ref,
   input wire hdlcr_pkg::hdlcr_ref_sel_type ref_select,
   input wire logic [8:0] drive_amplitude
);
   import hdlcr_pkg::*;

   // Reset falls by a non-blocking update on a clock edge.
   // The flops still take their reset values on that edge.
   // This flag keeps every attempt from that edge disabled, so no false fire follows reset.
   logic rst_hold_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rst_hold_q <= 1'b1;
      end else begin
         rst_hold_q <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || rst_hold_q);

   // Boost covers both automatic overdrive and automatic braking.
   wire logic boost = closed_loop && (overdrive_active || brake_active);

   // Multi-step antecedents: result load followed by a read of that result, or a limit or nominal write followed by one more cycle.
   sequence s_comp_rd; cal_done ##1 (reg_rd && reg_addr == OFF_LOSS_COMP); endsequence
   // A host write between the load and the read would legally replace the result.
   sequence s_bemf_rd; cal_done ##1 !(reg_wr && reg_addr == OFF_BACKEMF_CAL)
      ##1 (reg_rd && reg_addr == OFF_BACKEMF_CAL); endsequence
   sequence s_limit_wr; (reg_wr && reg_addr == OFF_OVERDRIVE_LIMIT && !closed_loop) ##1 !closed_loop;
   endsequence
   sequence s_nom_wr; (reg_wr && reg_addr == OFF_NOMINAL_LEVEL)
      ##1 !(reg_wr && reg_addr == OFF_NOMINAL_LEVEL); endsequence

   property p_ref_open; !closed_loop |=> ref_select == REF_LIMIT_OPEN; endproperty
   property p_ref_boost; boost |=> ref_select == REF_LIMIT_BOOST; endproperty
   property p_ref_nom; closed_loop && !boost |=> ref_select == REF_NOMINAL; endproperty
   property p_cal_comp; s_comp_rd |=> reg_rdata == $past(cal_comp_value, 2); endproperty
   property p_cal_bemf; s_bemf_rd |=> reg_rdata == $past(cal_bemf_value, 3); endproperty
   property p_od_bound; boost |=> drive_amplitude <= {1'b0, full_scale_ref}; endproperty
   property p_fs_limit; s_limit_wr |=> full_scale_ref == $past(reg_wdata, 2); endproperty
   property p_cal_ref; s_nom_wr |=> calib_reference == $past(reg_wdata, 2); endproperty

   a_ref_open: assert property (p_ref_open) else $error("open loop not on limit");
   a_ref_boost: assert property (p_ref_boost) else $error("boost not on limit");
   a_ref_nom: assert property (p_ref_nom) else $error("closed loop not on nominal");
   a_cal_comp: assert property (p_cal_comp) else $error("comp result not loaded");
   backemf_calibration_result: assert property (p_cal_bemf) else $error("bemf result not loaded");
   a_od_bound: assert property (p_od_bound) else $error("overdrive above limit");
   a_fs_limit: assert property (p_fs_limit) else $error("open loop ref stale");
   a_cal_ref: assert property (p_cal_ref) else $error("calibration ref stale");
endmodule

bind hdlcr_top hdlcr_monitor i_mon (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .closed_loop, .overdrive_active, .brake_active, .cal_done, .cal_comp_value,
   .cal_bemf_value, .calib_reference, .full_scale_ref, .ref_select, .drive_amplitude);

`default_nettype wire

// ===== sim/hdlcr_cal_engine.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the calibration routine that feeds the result registers.
module hdlcr_cal_engine (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [3:0] latency,
   input wire logic [7:0] nominal_level,
   input wire logic [7:0] comp_in,
   input wire logic [7:0] bemf_in,
   output logic cal_done,
   output logic [7:0] cal_comp_value,
   output logic [7:0] cal_bemf_value
);
   logic [4:0] cnt_q;

   // Results are valid only with the done pulse; elsewhere they toggle each cycle,
   // so a sampler that looks at the wrong cycle picks up garbage.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 5'h00;
         cal_done <= 1'b0;
         cal_comp_value <= 8'h00;
         cal_bemf_value <= 8'h00;
      end else begin
         if (start) begin
            cnt_q <= {1'b0, latency} + 5'h01;
         end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
         end
         cal_done <= (cnt_q == 5'h01);
         cal_comp_value <= (cnt_q == 5'h01) ? comp_in : ~cal_comp_value;
         cal_bemf_value <= (cnt_q == 5'h01) ? bemf_in ^ nominal_level : ~cal_bemf_value;
      end
   end
endmodule

`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module tb;
   import hdlcr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic closed_loop = 1'b0;
   logic overdrive_active = 1'b0;
   logic brake_active = 1'b0;
   logic [1:0] feedback_sense_gain_select = 2'h0;
   logic [7:0] ath_level_in = 8'h00;
   logic [7:0] drive_request = 8'h00;
   logic cal_start = 1'b0;
   logic [3:0] cal_lat = 4'h0;
   logic [7:0] comp_in = 8'h00;
   logic [7:0] bemf_in = 8'h00;
   logic cal_done, chk_pend = 1'b0, stale = 1'b0, seen = 1'b0;
   logic [7:0] cal_comp_value, cal_bemf_value, reg_rdata, calib_reference, full_scale_ref;
   logic [7:0] ath_drive_level, feedback_gain, chk_val;
   logic [8:0] drive_amplitude;
   logic [15:0] backemf_sense_mv;
   hdlcr_ref_sel_type ref_select;
   logic [31:0] seed = 32'he655;
   logic [7:0] rm [6];
   logic [7:0] corner [6] = '{8'hc0, 8'h40, 8'hff, 8'h00, 8'hff, 8'h00};
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;

   hdlcr_top i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .closed_loop, .overdrive_active, .brake_active, .feedback_sense_gain_select, .cal_done,
      .cal_comp_value, .cal_bemf_value, .ath_level_in, .drive_request, .calib_reference,
      .full_scale_ref, .ref_select, .ath_drive_level, .drive_amplitude, .feedback_gain,
      .backemf_sense_mv);
   hdlcr_cal_engine i_cal (.clk, .rst, .start(cal_start), .latency(cal_lat),
      .nominal_level(calib_reference), .comp_in, .bemf_in, .cal_done, .cal_comp_value,
      .cal_bemf_value);

   // Free-running clock; a hung run is cut off long after the tests should end.
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         finish_test();
      end
   end

   // Read data stands only in the cycle after the strobe, so it is sampled mid-cycle.
   always @(negedge clk) begin
      if (chk_pend) begin
         `CHK(reg_rdata, chk_val)
         chk_pend = 1'b0;
      end
   end

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   function automatic logic boost();
      return closed_loop && (overdrive_active || brake_active);
   endfunction

   function automatic int fs();
      return (!closed_loop || boost()) ? int'(rm[3]) : int'(rm[2]);
   endfunction

   function automatic hdlcr_ref_sel_type exp_sel();
      return !closed_loop ? REF_LIMIT_OPEN : (boost() ? REF_LIMIT_BOOST : REF_NOMINAL);
   endfunction

   function automatic logic [8:0] exp_amp();
      int s = int'(drive_request) * fs() / 255;
      int d = s + s * int'(rm[4]) / 255;
      if (boost() && d > int'(rm[3])) d = int'(rm[3]);
      return 9'(d);
   endfunction

   // Floor is applied first so that the ceiling wins when the two cross.
   function automatic logic [7:0] exp_ath();
      logic [7:0] v = (ath_level_in < rm[0]) ? rm[0] : ath_level_in;
      if (v > rm[1]) v = rm[1];
      return (ath_level_in == 8'h00) ? 8'h00 : v;
   endfunction

   function automatic logic [7:0] exp_gain();
      int g = (rm[5] == 8'h00) ? 255 : 8160 / int'(rm[5]);
      return (g > 255) ? 8'hff : 8'(g);
   endfunction

   function automatic logic [15:0] exp_mv();
      return 16'((int'(rm[5]) * 1220 / 255) * 10 / (10 << feedback_sense_gain_select));
   endfunction

   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a >= OFF_DRIVE_FLOOR && a <= OFF_BACKEMF_CAL) rm[a - OFF_DRIVE_FLOOR] = d;
      if (a == OFF_NOMINAL_LEVEL) stale = 1'b1;
      op(1'b1, 1'b0, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      op(1'b0, 1'b1, a, 8'h00);
      chk_val = e;
      chk_pend = 1'b1;
   endtask

   // Random engine inputs, then every derived output is checked one cycle later.
   task automatic engine();
      logic [7:0] r = rnd();
      closed_loop <= r[0];
      overdrive_active <= r[1] & r[2];
      brake_active <= r[3] & r[4];
      feedback_sense_gain_select <= r[6:5];
      ath_level_in <= r[7] ? rnd() : {4'h0, r[3:0]};
      drive_request <= rnd();
      @(posedge clk);
      @(negedge clk);
      `CHK(full_scale_ref, 8'(fs()))
      `CHK(ref_select, exp_sel())
      `CHK(drive_amplitude, exp_amp())
      `CHK(ath_drive_level, exp_ath())
      `CHK(feedback_gain, exp_gain())
      `CHK(backemf_sense_mv, exp_mv())
      `CHK(calib_reference, rm[2])
      @(posedge clk);
   endtask

   task automatic cal(input logic [3:0] lat, input logic [7:0] c, input logic [7:0] b);
      int n = 0;
      cal_lat <= lat;
      comp_in <= c;
      bemf_in <= b;
      cal_start <= 1'b1;
      @(posedge clk);
      cal_start <= 1'b0;
      while (cal_done !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n == 40) mismatches++;
      rm[4] = c;
      rm[5] = b ^ rm[2];
      seen = 1'b1;
      stale = 1'b0;
   endtask

   task automatic finish_test();
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Reset values, back-to-back writes and reads, engine sweeps, then calibration runs.
   initial begin
      rm = '{RST_DRIVE_FLOOR, RST_DRIVE_CEILING, RST_NOMINAL_LEVEL, RST_OVERDRIVE_LIMIT,
         RST_LOSS_COMP, RST_BACKEMF_CAL};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 6; i++) rd(OFF_DRIVE_FLOOR + 8'(i), rm[i]);
      rd(OFF_CAL_STATUS, 8'h00);
      rd(8'h1a, 8'h00);
      for (int p = 0; p < 4; p++) begin
         for (int i = 0; i < 6; i++) wr(OFF_DRIVE_FLOOR + 8'(i), p == 0 ? corner[i] : rnd());
         wr(8'h20, rnd());
         wr(OFF_CAL_STATUS, 8'hff);
         for (int i = 0; i < 6; i++) rd(OFF_DRIVE_FLOOR + 8'(i), rm[i]);
         rd(8'h20, 8'h00);
         rd(OFF_CAL_STATUS, {6'h00, seen, stale});
         op(1'b0, 1'b0, 8'h00, 8'h00);
         for (int k = 0; k < 10; k++) engine();
      end
      for (int j = 0; j < 2; j++) begin
         wr(OFF_NOMINAL_LEVEL, rnd());
         op(1'b0, 1'b0, 8'h00, 8'h00);
         cal(j == 0 ? 4'h0 : 4'h9, rnd(), rnd());
         rd(OFF_LOSS_COMP, rm[4]);
         rd(OFF_BACKEMF_CAL, rm[5]);
         rd(OFF_CAL_STATUS, {6'h00, seen, stale});
         op(1'b0, 1'b0, 8'h00, 8'h00);
         for (int k = 0; k < 4; k++) engine();
      end
      finish_test();
   end
endmodule

`default_nettype wire
